//--- design/mpp_power_map.vh
// constants for the memory page power controller
// assumes inclusion by bare name from design files only
`ifndef MPP_POWER_MAP_VH
`define MPP_POWER_MAP_VH

// core count and page count
`define MPP_NUM_CORES 6
`define MPP_NUM_PAGES 2
// local ram page sizes in bytes (512K and 96K)
`define MPP_LOC_PAGE0_SIZE 20'h80000
`define MPP_LOC_PAGE1_SIZE 20'h18000
`define MPP_LOC_ADDR_W 20
// shared ram page sizes in bytes (512K and 256K)
`define MPP_SH_PAGE0_SIZE 20'h80000
`define MPP_SH_PAGE1_SIZE 20'h40000
`define MPP_SH_ADDR_W 20
// shared permit word: page 0 bit 2, page 1 bit 3
`define MPP_SH_P0_BIT 2
`define MPP_SH_P1_BIT 3
// local command word: page 0 bit 0, page 1 bit 1
`define MPP_LOC_P0_BIT 0
`define MPP_LOC_P1_BIT 1
// privilege modes
`define MPP_MODE_USER 2'h0
`define MPP_MODE_SUP 2'h1
`define MPP_MODE_SUSER 2'h2
`define MPP_MODE_SSUP 2'h3
// window after a sleep request in which an access drops it
`define MPP_DROP_WIN_NS 64
`define MPP_CLK_NS 8
`define MPP_DROP_CYC ((`MPP_DROP_WIN_NS) / (`MPP_CLK_NS))
// cycles a page takes to finish a sleep or wake transition
`define MPP_TRANS_CYC 4'h4
// page state reset value: both pages awake
`define MPP_AWAKE_RST 2'h0

`endif

//--- design/mpp_page_ctrl.v
// one page power controller: sleep/wake transition with status
// assumes one-cycle sleep and wake request pulses, wake beats sleep
`timescale 1ns/1ps
`default_nettype none
`include "mpp_power_map.vh"

module mpp_page_ctrl (
    // clock and reset
    input wire clk_sys,
    input wire arst_n,
    // requests
    input wire sleepReq,
    input wire wakeReq,
    // status
    output reg asleep,
    output wire busy
);

reg [3:0] count_reg;
reg target_reg;

// transition timer; wake always overrides a pending or done sleep
always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        count_reg <= 4'h0;
        target_reg <= 1'b0;
        asleep <= 1'b0;
    end else if (wakeReq && (asleep || target_reg)) begin
        target_reg <= 1'b0;
        count_reg <= `MPP_TRANS_CYC;
    end else if (sleepReq && !wakeReq && !asleep && !target_reg) begin
        target_reg <= 1'b1;
        count_reg <= `MPP_TRANS_CYC;
    end else if (count_reg != 4'h0) begin
        count_reg <= count_reg - 4'h1;
        // status changes only when the transition completes
        if (count_reg == 4'h1) begin
            asleep <= target_reg;
        end
    end
end

assign busy = (count_reg != 4'h0);

endmodule // mpp_page_ctrl

`default_nettype wire

//--- design/mpp_power_ctrl.v
// page sleep/wake control for per-core local ram and shared ram
// assumes core requests synchronous to clk_sys, one-cycle write pulses
`timescale 1ns/1ps
`default_nettype none
`include "mpp_power_map.vh"

module mpp_power_ctrl (
    // clock and reset
    input wire clk_sys,
    input wire arst_n,
    // local command writes, one strobe per core, 2 bits per core
    input wire [5:0] locSleepWr,
    input wire [5:0] locWakeWr,
    input wire [11:0] locCmdData,
    // local ram accesses from any core: target core, start, length
    input wire locAccValid,
    input wire [2:0] locAccCore,
    input wire [19:0] locAccAddr,
    input wire [19:0] locAccLen,
    // shared permit writes, one strobe per core, 32-bit word per core
    input wire [5:0] shSleepWr,
    input wire [5:0] shWakeWr,
    input wire [5:0] shRd,
    input wire [191:0] shPermitData,
    input wire [11:0] shMode,
    // shared ram accesses
    input wire shAccValid,
    input wire [19:0] shAccAddr,
    input wire [19:0] shAccLen,
    // status and answers
    output wire [11:0] locPowerStatus,
    output wire [1:0] shPowerStatus,
    output reg [31:0] shPermitRdData,
    output reg [5:0] privException,
    output wire locStall
);

// mask of the pages that an access touches, from its start, length and 512K page-0 size
function [1:0] pagesTouched;
    input [19:0] addr;
    input [19:0] len;
    input [19:0] p0size;
    reg [20:0] last;
    begin
        last = {1'b0, addr} + {1'b0, len} - 21'h1;
        pagesTouched[0] = (addr < p0size);
        pagesTouched[1] = (last >= {1'b0, p0size}) || (addr >= p0size);
    end
endfunction

// true for supervisor and secure supervisor modes
function isSupervisor;
    input [1:0] mode;
    begin
        isSupervisor = (mode == `MPP_MODE_SUP) || (mode == `MPP_MODE_SSUP);
    end
endfunction

wire [1:0] locHit;
wire [1:0] shHit;
wire [11:0] locBusy;
wire [1:0] shBusy;
wire [1:0] shAsleep;
reg [11:0] locSleepReq;
reg [11:0] locWakeReq;
reg [11:0] locPending_reg;
reg [11:0] locPending_next;
reg [4:0] dropCnt_reg [0:11];
reg [1:0] shSleepPermit_reg [0:5];
reg [1:0] shSleepPermit_next [0:5];
reg [1:0] shWakeReq;
reg [1:0] shAllPermit;
reg [5:0] privException_next;
// own loop indices per process, so no process wakes another through a shared index
integer lc;
integer lp;
integer li;
integer sc;
integer si;
// sleep request window length in cycles, loaded into a 5-bit counter
localparam integer DROP_CYC = `MPP_DROP_CYC;

assign locHit = locAccValid ? pagesTouched(locAccAddr, locAccLen, `MPP_LOC_PAGE0_SIZE) : 2'h0;
assign shHit = shAccValid ? pagesTouched(shAccAddr, shAccLen, `MPP_SH_PAGE0_SIZE) : 2'h0;

// local sleep and wake requests per core page
always @* begin
    locSleepReq = 12'h000;
    locWakeReq = 12'h000;
    locPending_next = locPending_reg;
    for (lc = 0; lc < `MPP_NUM_CORES; lc = lc + 1) begin
        for (lp = 0; lp < `MPP_NUM_PAGES; lp = lp + 1) begin
            if (locSleepWr[lc] && locCmdData[2*lc+lp]) begin
                locPending_next[2*lc+lp] = 1'b1;
            end
            if (locWakeWr[lc] && locCmdData[2*lc+lp]) begin
                locWakeReq[2*lc+lp] = 1'b1;
            end
            if (locHit[lp] && (locAccCore == lc[2:0])) begin
                locWakeReq[2*lc+lp] = 1'b1;
            end
            // drop when busy or accessed in window
            if (locPending_reg[2*lc+lp]) begin
                if (locWakeReq[2*lc+lp] || locBusy[2*lc+lp]) begin
                    locPending_next[2*lc+lp] = 1'b0;
                end else if (dropCnt_reg[2*lc+lp] == 5'h0) begin
                    locSleepReq[2*lc+lp] = 1'b1;
                    locPending_next[2*lc+lp] = 1'b0;
                end
            end
        end
    end
end

// request window counters and pending flags
always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        locPending_reg <= 12'h000;
        for (li = 0; li < 12; li = li + 1) begin
            dropCnt_reg[li] <= 5'h0;
        end
    end else begin
        locPending_reg <= locPending_next;
        for (li = 0; li < 12; li = li + 1) begin
            if (locSleepWr[li/2] && locCmdData[li] && !locPending_reg[li]) begin
                dropCnt_reg[li] <= DROP_CYC[4:0];
            end else if (dropCnt_reg[li] != 5'h0) begin
                dropCnt_reg[li] <= dropCnt_reg[li] - 5'h1;
            end
        end
    end
end

// two local pages per core, reset awake
genvar g;
generate
    for (g = 0; g < 12; g = g + 1) begin : gLocPage
        mpp_page_ctrl uLoc (
            .clk_sys(clk_sys),
            .arst_n(arst_n),
            .sleepReq(locSleepReq[g]),
            .wakeReq(locWakeReq[g]),
            .asleep(locPowerStatus[g]),
            .busy(locBusy[g])
        );
    end
    for (g = 0; g < 2; g = g + 1) begin : gShPage
        mpp_page_ctrl uSh (
            .clk_sys(clk_sys),
            .arst_n(arst_n),
            .sleepReq(shAllPermit[g]),
            .wakeReq(shWakeReq[g]),
            .asleep(shAsleep[g]),
            .busy(shBusy[g])
        );
    end
endgenerate

// stall while an asleep local page wakes
// a page still marked asleep but busy is on its way up; a sleep in progress does not stall
assign locStall = |(locBusy & locPowerStatus);
assign shPowerStatus = shAsleep;

// shared permit handling
always @* begin
    shWakeReq = shHit;
    privException_next = 6'h00;
    for (sc = 0; sc < `MPP_NUM_CORES; sc = sc + 1) begin
        shSleepPermit_next[sc] = shSleepPermit_reg[sc];
        if (shSleepWr[sc] || shWakeWr[sc]) begin
            if (isSupervisor(shMode[2*sc+:2])) begin
                if (shSleepWr[sc] && !shBusy[0] && !shBusy[1]) begin
                    shSleepPermit_next[sc] = shSleepPermit_reg[sc] | {shPermitData[32*sc+`MPP_SH_P1_BIT],
                        shPermitData[32*sc+`MPP_SH_P0_BIT]};
                end
                if (shWakeWr[sc]) begin
                    shWakeReq = shWakeReq | {shPermitData[32*sc+`MPP_SH_P1_BIT],
                        shPermitData[32*sc+`MPP_SH_P0_BIT]};
                end
            end else begin
                privException_next = 6'h3F;
            end
        end
    end
    shAllPermit = 2'h3;
    for (sc = 0; sc < `MPP_NUM_CORES; sc = sc + 1) begin
        shAllPermit = shAllPermit & shSleepPermit_reg[sc];
    end
    shAllPermit = shAllPermit & ~shWakeReq;
end

// permits, consumed once a page has gone to sleep or a wake is requested
always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        for (si = 0; si < 6; si = si + 1) begin
            shSleepPermit_reg[si] <= 2'h0;
        end
        privException <= 6'h00;
        shPermitRdData <= 32'h00000000;
    end else begin
        for (si = 0; si < 6; si = si + 1) begin
            shSleepPermit_reg[si] <= shSleepPermit_next[si] & ~shWakeReq & ~shAsleep;
        end
        privException <= privException_next;
        if (|shRd) begin
            shPermitRdData <= 32'h00000000;
        end
    end
end

endmodule // mpp_power_ctrl

`default_nettype wire

//--- sim/mpp_core_model.sv
// core-side model: shared permit writes with status polling
// assumes the shared ports of mpp_power_ctrl on clk_sys
`timescale 1ns/1ps
`default_nettype none
module mpp_core_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // scenario controls
    input wire logic wantSleep, wantWake, userMode,
    input wire logic [5:0] permitMask,
    // shared permit side
    input wire logic [1:0] shPowerStatus,
    output logic [5:0] shSleepWr, shWakeWr,
    output logic [191:0] shPermitData,
    output logic [11:0] shMode
);
    logic [3:0] pollCnt_reg;
    // page 1 bit for every core; user and secure user mixed, else supervisor and secure supervisor mixed
    assign shMode = userMode ? 12'h888 : 12'h777;
    assign shPermitData = {6{32'h00000008}};
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pollCnt_reg <= 4'h0;
            shSleepWr <= 6'h00;
            shWakeWr <= 6'h00;
        end else begin
            pollCnt_reg <= pollCnt_reg + 4'h1;
            shSleepWr <= (pollCnt_reg == 4'hF && wantSleep && !shPowerStatus[1]) ? permitMask : 6'h00;
            shWakeWr <= (pollCnt_reg == 4'hF && wantWake && shPowerStatus[1]) ? 6'h01 : 6'h00;
        end
    end
endmodule // mpp_core_model
`default_nettype wire

//--- sim/mpp_power_ctrl_checker.sv
// checker on the ports of mpp_power_ctrl
// assumes one clock domain, bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module mpp_power_ctrl_checker (
    input wire logic clk_sys, arst_n, locAccValid, shAccValid, locStall,
    input wire logic [5:0] locSleepWr, locWakeWr, shSleepWr, shWakeWr, privException,
    input wire logic [11:0] locCmdData, shMode, locPowerStatus,
    input wire logic [19:0] locAccAddr, locAccLen, shAccAddr, shAccLen,
    input wire logic [2:0] locAccCore,
    input wire logic [191:0] shPermitData,
    input wire logic [1:0] shPowerStatus,
    input wire logic [31:0] shPermitRdData
);
    logic [5:0] userWr;
    // permit writes issued from a user mode
    always_comb begin
        for (int c = 0; c < 6; c++) userWr[c] = (shSleepWr[c] | shWakeWr[c]) & !shMode[2*c];
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence s_locWake; ##[1:8] !locPowerStatus[0]; endsequence
    sequence s_locWake1; ##[1:8] !locPowerStatus[1]; endsequence
    sequence s_shWake; ##[1:8] !shPowerStatus[1]; endsequence
    a_read_zero: assert property (shPermitRdData == 32'h0) else $error("permit read not zero");
    a_user_exc: assert property (|userWr |=> privException == 6'h3F) else $error("no exception");
    a_no_exc: assert property (!(|userWr) |=> privException == 6'h00) else $error("stray exception");
    a_loc_sleep: assert property ($rose(locPowerStatus[0]) |-> $past(locSleepWr[0] && locCmdData[0], 14))
        else $error("local sleep timing");
    a_loc_wake: assert property (locWakeWr[0] && locCmdData[0] && locPowerStatus[0] |-> s_locWake)
        else $error("local wake missed");
    a_wake_stall: assert property (locWakeWr[0] && locCmdData[0] && locPowerStatus[0] |=> ##[0:4] locStall)
        else $error("no stall on wake");
    a_loc_access: assert property (locAccValid && locAccCore == 3'h0
        && ({1'b0, locAccAddr} + {1'b0, locAccLen}) > 21'h80000
        && locPowerStatus[1] |-> s_locWake1) else $error("access wake missed");
    a_sh_sleep: assert property ($rose(shPowerStatus[1]) |-> $past(shSleepWr == 6'h3F, 6))
        else $error("shared sleep without all permits");
    a_sh_wake: assert property (shWakeWr[0] && shPermitData[3] && shMode[0] && shPowerStatus[1]
        |-> s_shWake) else $error("shared wake missed");
    a_sh_access: assert property (shAccValid && ({1'b0, shAccAddr} + {1'b0, shAccLen}) > 21'h80000
        && shPowerStatus[1] |-> s_shWake) else $error("shared access wake missed");
endmodule // mpp_power_ctrl_checker
bind mpp_power_ctrl mpp_power_ctrl_checker chk (.*);
`default_nettype wire

//--- sim/mpp_power_ctrl_tb.sv
// testbench for mpp_power_ctrl with the core model on the shared side
// assumes 125 MHz clk_sys and the checker bound to the design
`timescale 1ns/1ps
`default_nettype none
module mpp_power_ctrl_tb;
    logic clk_sys = 1'b0, arst_n = 1'b0, locAccValid = 1'b0, shAccValid = 1'b0, locStall;
    logic wantSleep = 1'b0, wantWake = 1'b0, userMode = 1'b0;
    logic [5:0] locSleepWr = 6'h00, locWakeWr = 6'h00, shRd = 6'h00, permitMask = 6'h3F;
    logic [5:0] shSleepWr, shWakeWr, privException;
    logic [11:0] locCmdData = 12'h000, shMode, locPowerStatus;
    logic [2:0] locAccCore = 3'h0;
    logic [19:0] locAccAddr = 20'h0, locAccLen = 20'h0, shAccAddr = 20'h0, shAccLen = 20'h0;
    logic [191:0] shPermitData;
    logic [1:0] shPowerStatus;
    logic [31:0] shPermitRdData;
    int failures = 0, tests_run = 0, cycles = 0;
    mpp_power_ctrl uut (.*);
    mpp_core_model core (.*);
    always #4 clk_sys = ~clk_sys;
    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            report_and_stop;
        end
    end
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task locCmd(input logic sleep, input int c, input logic [1:0] pages);
        @(posedge clk_sys);
        locCmdData <= {10'h000, pages} << (2 * c);
        if (sleep) locSleepWr <= 6'h01 << c;
        else locWakeWr <= 6'h01 << c;
        @(posedge clk_sys);
        locSleepWr <= 6'h00;
        locWakeWr <= 6'h00;
    endtask
    task locAcc(input logic [2:0] c, input logic [19:0] addr, len);
        @(posedge clk_sys);
        locAccValid <= 1'b1;
        locAccCore <= c;
        locAccAddr <= addr;
        locAccLen <= len;
        @(posedge clk_sys);
        locAccValid <= 1'b0;
    endtask
    task waitSh(input logic v, input string what);
        for (int i = 0; i < 120 && shPowerStatus[1] !== v; i++) tick(1);
        chk(what, {31'h0, v}, {31'h0, shPowerStatus[1]});
    endtask
    task t_local;
        locCmd(1'b1, 0, 2'b11);
        locCmd(1'b1, 1, 2'b00);
        tick(16);
        chk("local sleep", 12'h003, locPowerStatus);
        locCmd(1'b0, 0, 2'b01);
        tick(10);
        chk("local wake", 12'h002, locPowerStatus);
        locAcc(3'h0, 20'h7FFF0, 20'h00020);
        tick(10);
        chk("crossing access", 12'h000, locPowerStatus);
        locCmd(1'b1, 2, 2'b01);
        tick(2);
        locAcc(3'h2, 20'h00100, 20'h00004);
        tick(20);
        chk("dropped sleep", 12'h000, locPowerStatus);
    endtask
    task t_shared;
        permitMask <= 6'h1F;
        wantSleep <= 1'b1;
        tick(60);
        chk("one core withholds", 32'h0, {30'h0, shPowerStatus});
        permitMask <= 6'h3F;
        waitSh(1'b1, "all permit");
        @(posedge clk_sys);
        shRd <= 6'h01;
        @(posedge clk_sys);
        shRd <= 6'h00;
        tick(1);
        chk("permit read", 32'h0, shPermitRdData);
        wantSleep <= 1'b0;
        wantWake <= 1'b1;
        waitSh(1'b0, "wake permit");
        wantWake <= 1'b0;
        wantSleep <= 1'b1;
        waitSh(1'b1, "sleep again");
        wantSleep <= 1'b0;
        @(posedge clk_sys);
        shAccValid <= 1'b1;
        shAccAddr <= 20'h7FFFC;
        shAccLen <= 20'h00008;
        @(posedge clk_sys);
        shAccValid <= 1'b0;
        waitSh(1'b0, "shared access");
        userMode <= 1'b1;
        wantSleep <= 1'b1;
        for (int i = 0; i < 40 && privException === 6'h00; i++) tick(1);
        chk("exception", 32'h3F, {26'h0, privException});
        tick(40);
        chk("user write ignored", 32'h0, {30'h0, shPowerStatus});
    endtask
    task report_and_stop;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // reset, then the scenarios
    initial begin
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        tick(1);
        chk("reset local", 32'h0, {20'h0, locPowerStatus});
        chk("reset shared", 32'h0, {30'h0, shPowerStatus});
        t_local;
        t_shared;
        report_and_stop;
    end
endmodule // mpp_power_ctrl_tb
`default_nettype wire
